// >>> rtl/pmt_pkg.sv
/*
 Shared constants, types and timing helpers for the proximity
 measurement sequencer and its bus controller.
 Assumes one 50 MHz clock shared by both ends.
*/
package pmt_pkg;

    // ----------
    // clock
    // ----------
    localparam int CLK_MHZ  = 50;
    localparam int TICK_CYC = CLK_MHZ;

    // ----------
    // command codes
    // ----------
    localparam logic [7:0] CMD_CONF1  = 8'h00;
    localparam logic [7:0] CMD_CONF2  = 8'h03;
    localparam logic [7:0] CMD_CONF3  = 8'h04;
    localparam logic [7:0] CMD_THR_LO = 8'h05;
    localparam logic [7:0] CMD_THR_HI = 8'h06;
    localparam logic [7:0] CMD_RESULT = 8'hF8;
    localparam logic [7:0] CMD_FLAGS  = 8'hF9;

    // ----------
    // field positions
    // ----------
    localparam int F1_POWER   = 0;
    localparam int F1_CAL     = 7;
    localparam int F2_PER_LSB = 0;
    localparam int F2_ITB     = 2;
    localparam int F2_IT_LSB  = 3;
    localparam int F2_FORCE   = 6;
    localparam int F2_TRIG    = 7;
    localparam int F3_MPS_LSB = 0;
    localparam int FL_NEAR    = 0;
    localparam int FL_FAR     = 1;

    // ----------
    // reset values and corrupt read value
    // ----------
    localparam logic [15:0] CONF_RST    = 16'h0000;
    localparam logic [15:0] THR_LO_RST  = 16'h0000;
    localparam logic [15:0] THR_HI_RST  = 16'hFFFF;
    localparam logic [15:0] CORRUPT_VAL = 16'h07FF;

    // ----------
    // times in microseconds, spread ratio and init step count
    // ----------
    localparam int T_CANCEL_25_US = 450;
    localparam int T_CANCEL_50_US = 900;
    localparam int T_ITB_25_US    = 25;
    localparam int T_ITB_50_US    = 50;
    localparam int T_POR_US       = 2500;
    localparam int T_WR_STD_US    = 400;
    localparam int T_RD_STD_US    = 500;
    localparam int T_PER0_US      = 12500;
    localparam int T_PER1_US      = 25000;
    localparam int T_PER2_US      = 50000;
    localparam int T_PER3_US      = 100000;
    localparam int SPREAD_NUM     = 6;
    localparam int SPREAD_DEN     = 5;
    localparam int INIT_STEPS     = 6;

    typedef logic [16:0] pmt_us_t;

    function automatic pmt_us_t pmt_cancel_us(input logic itb);
        return itb ? 17'(T_CANCEL_50_US) : 17'(T_CANCEL_25_US);
    endfunction : pmt_cancel_us

    // it and mps are stored minus one
    function automatic pmt_us_t pmt_integ_us(input logic itb,
                                             input logic [2:0] it,
                                             input logic [2:0] mps);
        int base;
        base = itb ? T_ITB_50_US : T_ITB_25_US;
        return 17'(2 * (int'(it) + 1) * base * (int'(mps) + 1));
    endfunction : pmt_integ_us

    function automatic pmt_us_t pmt_period_us(input logic [1:0] sel);
        unique case (sel)
            2'h0:    return 17'(T_PER0_US);
            2'h1:    return 17'(T_PER1_US);
            2'h2:    return 17'(T_PER2_US);
            default: return 17'(T_PER3_US);
        endcase
    endfunction : pmt_period_us

endpackage : pmt_pkg

// >>> rtl/pmt_link_if.sv
/*
 Command link between controller and sensor.
 Assumes both ends on the same clock.
*/
`timescale 1ns/10ps
interface pmt_link_if;
    logic        req;
    logic        wr;
    logic        rstart;
    logic [7:0]  cmd;
    logic [15:0] wdata;
    logic        ack;
    logic [15:0] rdata;
    logic        int_n;

    modport dev  (input  req, wr, rstart, cmd, wdata,
                  output ack, rdata, int_n);
    modport host (output req, wr, rstart, cmd, wdata,
                  input  ack, rdata, int_n);
endinterface : pmt_link_if

// >>> rtl/pmt_timer.sv
/*
 Microsecond down-timer with a one-cycle done pulse.
 Assumes load_us is at least one.
*/
`timescale 1ns/10ps
module pmt_timer
    import pmt_pkg::*;
#(
    parameter int TICK = TICK_CYC
) (
    input  wire logic    clk_sys, // clock
    input  wire logic    rst,     // async reset
    input  wire logic    start,   // load pulse
    input  wire pmt_us_t load_us, // duration
    output logic         done,    // end pulse
    output logic         busy     // counting
);
    logic [15:0] pre_r;
    pmt_us_t     left_r;
    logic        tick;

    assign tick = (pre_r == 16'(TICK - 1));
    assign busy = (left_r != '0);

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            pre_r  <= '0;
            left_r <= '0;
        end else if (start) begin
            pre_r  <= '0;
            left_r <= load_us;
        end else if (busy) begin
            pre_r  <= tick ? 16'h0000 : pre_r + 16'h0001;
            if (tick) begin
                left_r <= left_r - 17'h00001;
            end
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            done <= 1'b0;
        end else begin
            done <= !start && tick && (left_r == 17'h00001);
        end
    end
endmodule : pmt_timer

// >>> rtl/pmt_sensor.sv
/*
 Sensor end: command registers, measurement sequencer,
 event flags and interrupt line.
 Assumes ambient and reflected levels come from same-clock logic.
*/
// How it works
// - sample ambient first, subtract it from reflection
// - cancel step 450 us or 900 us
// - active time within spread of formula
// - controller waits active plus period after trigger
// - auto mode: one measurement per period
// - controller waits power-on interval before writes
// - controller init order, then power and calibration
// - interrupt low: read flags then result
// - controller spaces transactions by byte budget
// - controller waits for interrupt, no polling
// - reads need repeated start, else corrupt data
// - event flags stay set until flag read
`timescale 1ns/10ps
module pmt_sensor
    import pmt_pkg::*;
#(
    parameter int TICK = TICK_CYC
) (
    input  wire logic        clk_sys,     // clock
    input  wire logic        rst,         // async reset
    pmt_link_if.dev          link,        // controller link
    input  wire logic [15:0] ambient_lvl, // background level
    input  wire logic [15:0] reflect_lvl, // total reflection
    output logic             emitter_on,  // pulse phase
    output logic             measuring    // active phase
);

    typedef enum logic [1:0] {D_OFF, D_CANCEL, D_INTEG, D_WAIT} pmt_dst_t;

    // ----------
    // registers
    // ----------
    logic [15:0] conf1_r;
    logic [15:0] conf2_r;
    logic [15:0] conf3_r;
    logic [15:0] thr_lo_r;
    logic [15:0] thr_hi_r;
    logic [15:0] result_r;
    logic [15:0] amb_r;
    logic [1:0]  flags_r;
    logic [1:0]  flags_nxt;
    logic        trig_r;
    logic        ack_r;
    logic [15:0] rdata_r;
    logic        int_n_r;
    pmt_dst_t    st_r;
    logic        tmr_go_r;
    pmt_us_t     tmr_us_r;
    logic        tmr_done;

    // ----------
    // decode
    // ----------
    logic        wr_hit;
    logic        rd_hit;
    logic        itb;
    logic [2:0]  it_m1;
    logic [2:0]  mps_m1;
    logic        power;
    logic        force_md;
    logic        meas_done;
    logic [15:0] res_nxt;
    logic [1:0]  flag_set;
    logic        flag_clr;

    assign wr_hit   = link.req && link.wr;
    assign rd_hit   = link.req && !link.wr;
    assign itb      = conf2_r[F2_ITB];
    assign it_m1    = conf2_r[F2_IT_LSB +: 3];
    assign mps_m1   = conf3_r[F3_MPS_LSB +: 3];
    assign power    = conf1_r[F1_POWER];
    assign force_md = conf2_r[F2_FORCE];

    assign meas_done = (st_r == D_INTEG) && tmr_done;
    // background level removed, clamped at zero
    assign res_nxt = (reflect_lvl > amb_r) ? reflect_lvl - amb_r
                                           : 16'h0000;

    assign flag_set[FL_NEAR] = meas_done && (res_nxt > thr_hi_r);
    assign flag_set[FL_FAR]  = meas_done && (res_nxt < thr_lo_r);
    assign flag_clr  = rd_hit && (link.cmd == CMD_FLAGS);
    // new event beats the clearing read
    assign flags_nxt = (flags_r & {2{!flag_clr}}) | flag_set;

    // ----------
    // register writes
    // ----------
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            conf1_r  <= CONF_RST;
            conf2_r  <= CONF_RST;
            conf3_r  <= CONF_RST;
            thr_lo_r <= THR_LO_RST;
            thr_hi_r <= THR_HI_RST;
        end else if (wr_hit) begin
            unique case (link.cmd)
                CMD_CONF1:  conf1_r  <= link.wdata;
                CMD_CONF2:  conf2_r  <= link.wdata & ~(16'h0001 << F2_TRIG);
                CMD_CONF3:  conf3_r  <= link.wdata;
                CMD_THR_LO: thr_lo_r <= link.wdata;
                CMD_THR_HI: thr_hi_r <= link.wdata;
                default: ;
            endcase
        end
    end

    // trigger held until a forced measurement starts
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            trig_r <= 1'b0;
        end else if (wr_hit && link.cmd == CMD_CONF2 && link.wdata[F2_TRIG]) begin
            trig_r <= 1'b1;
        end else if (st_r == D_OFF && power) begin
            trig_r <= 1'b0;
        end
    end

    // ----------
    // read port
    // ----------
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ack_r   <= 1'b0;
            rdata_r <= '0;
        end else begin
            ack_r <= link.req;
            if (rd_hit && !link.rstart) begin
                rdata_r <= CORRUPT_VAL;
            end else if (rd_hit) begin
                unique case (link.cmd)
                    CMD_CONF1:  rdata_r <= conf1_r;
                    CMD_CONF2:  rdata_r <= conf2_r;
                    CMD_CONF3:  rdata_r <= conf3_r;
                    CMD_THR_LO: rdata_r <= thr_lo_r;
                    CMD_THR_HI: rdata_r <= thr_hi_r;
                    CMD_RESULT: rdata_r <= result_r;
                    CMD_FLAGS:  rdata_r <= {14'h0000, flags_r};
                    default:    rdata_r <= 16'h0000;
                endcase
            end
        end
    end

    // ----------
    // flags and interrupt
    // ----------
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            flags_r <= 2'h0;
            int_n_r <= 1'b1;
        end else begin
            flags_r <= flags_nxt;
            int_n_r <= !(|flags_nxt);
        end
    end

    // ----------
    // measurement sequencer
    // ----------
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            st_r     <= D_OFF;
            tmr_go_r <= 1'b0;
            tmr_us_r <= '0;
            amb_r    <= '0;
            result_r <= '0;
        end else begin
            tmr_go_r <= 1'b0;
            if (!power) begin
                st_r <= D_OFF;
            end else begin
                unique case (st_r)
                    D_OFF: begin
                        if (!force_md || trig_r) begin
                            st_r     <= D_CANCEL;
                            amb_r    <= ambient_lvl;
                            tmr_go_r <= 1'b1;
                            tmr_us_r <= pmt_cancel_us(itb);
                        end
                    end
                    D_CANCEL: begin
                        if (tmr_done) begin
                            st_r     <= D_INTEG;
                            tmr_go_r <= 1'b1;
                            tmr_us_r <= pmt_integ_us(itb, it_m1, mps_m1);
                        end
                    end
                    D_INTEG: begin
                        if (tmr_done) begin
                            result_r <= res_nxt;
                            st_r     <= force_md ? D_OFF : D_WAIT;
                            tmr_go_r <= !force_md;
                            // rest of the period after the active part
                            tmr_us_r <= pmt_period_us(conf2_r[F2_PER_LSB +: 2])
                                        - pmt_cancel_us(itb)
                                        - pmt_integ_us(itb, it_m1, mps_m1);
                        end
                    end
                    D_WAIT: begin
                        if (tmr_done) begin
                            st_r <= D_OFF;
                        end
                    end
                endcase
            end
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            emitter_on <= 1'b0;
            measuring  <= 1'b0;
        end else begin
            emitter_on <= power && (st_r == D_INTEG);
            measuring  <= power && (st_r == D_CANCEL || st_r == D_INTEG);
        end
    end

    pmt_timer #(
        .TICK    (TICK)
    ) u_tmr (
        .clk_sys (clk_sys),
        .rst     (rst),
        .start   (tmr_go_r),
        .load_us (tmr_us_r),
        .done    (tmr_done),
        .busy    ()
    );

    // ----------
    // link drive
    // ----------
    assign link.ack   = ack_r;
    assign link.rdata = rdata_r;
    assign link.int_n = int_n_r;

endmodule : pmt_sensor

// >>> rtl/pmt_ctrl.sv
/*
 Controller end: power-on wait, initialisation, then
 interrupt-driven or forced readout.
 Assumes config words are held steady by the user.
*/
`timescale 1ns/10ps
module pmt_ctrl
    import pmt_pkg::*;
#(
    parameter int TICK = TICK_CYC
) (
    input  wire logic        clk_sys,   // clock
    input  wire logic        rst,       // async reset
    pmt_link_if.host         link,      // sensor link
    input  wire logic        force_md,  // forced mode
    input  wire logic [15:0] cfg1,      // config word one
    input  wire logic [15:0] cfg2,      // config word two
    input  wire logic [15:0] cfg3,      // config word three
    input  wire logic [15:0] thr_lo,    // low threshold
    input  wire logic [15:0] thr_hi,    // high threshold
    output logic [15:0]      result,    // last result
    output logic             res_valid, // result pulse
    output logic [1:0]       flags,     // last flags
    output logic             ready      // init done
);

    typedef enum logic [3:0] {H_POR, H_INIT, H_LISTEN, H_FLAG, H_RES,
                              H_TRIG, H_FWAIT, H_XFER, H_GAP} pmt_hst_t;

    pmt_hst_t    st_r;
    pmt_hst_t    ret_r;
    logic [2:0]  step_r;
    logic        armed_r;
    logic        req_r;
    logic        wr_r;
    logic [7:0]  cmd_r;
    logic [15:0] wd_r;
    logic [15:0] rd_r;
    logic        tmr_go_r;
    pmt_us_t     tmr_us_r;
    logic        tmr_done;
    logic        tmr_busy;
    pmt_hst_t    nx_ret;
    logic        nx_go;
    logic        nx_wr;
    logic [7:0]  nx_cmd;
    logic [15:0] nx_wd;
    pmt_us_t     fwait_us;

    // ----------
    // forced wait
    // ----------
    assign fwait_us = 17'((int'(pmt_cancel_us(cfg2[F2_ITB]))
                      + int'(pmt_integ_us(cfg2[F2_ITB], cfg2[F2_IT_LSB +: 3],
                                          cfg3[F3_MPS_LSB +: 3])))
                      * SPREAD_NUM / SPREAD_DEN)
                      + pmt_period_us(cfg2[F2_PER_LSB +: 2]);

    // ----------
    // next transaction
    // ----------
    always_comb begin
        nx_go  = 1'b0;
        nx_wr  = 1'b0;
        nx_cmd = CMD_RESULT;
        nx_wd  = 16'h0000;
        nx_ret = H_LISTEN;
        unique case (st_r)
            H_INIT: begin
                nx_go  = (step_r != 3'(INIT_STEPS));
                nx_wr  = 1'b1;
                nx_ret = H_INIT;
                unique case (step_r)
                    3'h0:    begin nx_cmd = CMD_CONF1;  nx_wd = cfg1; end
                    3'h1:    begin nx_cmd = CMD_CONF2;  nx_wd = cfg2; end
                    3'h2:    begin nx_cmd = CMD_CONF3;  nx_wd = cfg3; end
                    3'h3:    begin nx_cmd = CMD_THR_LO; nx_wd = thr_lo; end
                    3'h4:    begin nx_cmd = CMD_THR_HI; nx_wd = thr_hi; end
                    default: begin
                        nx_cmd = CMD_CONF1;
                        nx_wd  = cfg1 | (16'h0001 << F1_POWER) | (16'h0001 << F1_CAL);
                    end
                endcase
            end
            H_LISTEN: begin
                nx_go  = !link.int_n;
                nx_cmd = CMD_FLAGS;
                nx_ret = H_FLAG;
            end
            H_FLAG: begin
                nx_go  = 1'b1;
                nx_ret = H_RES;
            end
            H_TRIG: begin
                nx_go  = 1'b1;
                nx_wr  = 1'b1;
                nx_cmd = CMD_CONF2;
                nx_wd  = cfg2 | (16'h0001 << F2_FORCE) | (16'h0001 << F2_TRIG);
                nx_ret = H_FWAIT;
            end
            H_FWAIT: begin
                nx_go  = tmr_done && armed_r;
                nx_ret = H_RES;
            end
            default: ;
        endcase
    end

    // ----------
    // sequencer
    // ----------
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            st_r     <= H_POR;
            ret_r    <= H_LISTEN;
            step_r   <= '0;
            armed_r  <= 1'b0;
            req_r    <= 1'b0;
            wr_r     <= 1'b0;
            cmd_r    <= '0;
            wd_r     <= '0;
            rd_r     <= '0;
            tmr_go_r <= 1'b0;
            tmr_us_r <= '0;
        end else begin
            req_r    <= 1'b0;
            tmr_go_r <= 1'b0;
            if (nx_go) begin
                st_r    <= H_XFER;
                ret_r   <= nx_ret;
                req_r   <= 1'b1;
                wr_r    <= nx_wr;
                cmd_r   <= nx_cmd;
                wd_r    <= nx_wd;
                armed_r <= 1'b0;
                if (st_r == H_INIT) begin
                    step_r <= step_r + 3'h1;
                end
            end else begin
                unique case (st_r)
                    H_POR, H_FWAIT: begin
                        if (!armed_r && !tmr_busy) begin
                            armed_r  <= 1'b1;
                            tmr_go_r <= 1'b1;
                            tmr_us_r <= (st_r == H_POR) ? 17'(T_POR_US)
                                                        : fwait_us;
                        end else if (tmr_done) begin
                            armed_r <= 1'b0;
                            st_r    <= H_INIT;
                        end
                    end
                    H_INIT:   st_r <= force_md ? H_TRIG : H_LISTEN;
                    H_XFER: begin
                        if (link.ack) begin
                            rd_r     <= link.rdata;
                            st_r     <= H_GAP;
                            tmr_go_r <= 1'b1;
                            tmr_us_r <= wr_r ? 17'(T_WR_STD_US)
                                             : 17'(T_RD_STD_US);
                        end
                    end
                    H_GAP:    if (tmr_done) st_r <= ret_r;
                    H_RES:    st_r <= force_md ? H_TRIG : H_LISTEN;
                    default: ;
                endcase
            end
        end
    end

    // ----------
    // user outputs
    // ----------
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            result    <= '0;
            res_valid <= 1'b0;
            flags     <= '0;
            ready     <= 1'b0;
        end else begin
            res_valid <= (st_r == H_RES);
            if (st_r == H_RES) result <= rd_r;
            if (st_r == H_FLAG) flags <= rd_r[1:0];
            if (st_r == H_LISTEN || st_r == H_TRIG) ready <= 1'b1;
        end
    end

    pmt_timer #(
        .TICK    (TICK)
    ) u_tmr (
        .clk_sys (clk_sys),
        .rst     (rst),
        .start   (tmr_go_r),
        .load_us (tmr_us_r),
        .done    (tmr_done),
        .busy    (tmr_busy)
    );

    // ----------
    // link drive
    // ----------
    assign link.req    = req_r;
    assign link.wr     = wr_r;
    assign link.rstart = 1'b1;
    assign link.cmd    = cmd_r;
    assign link.wdata  = wd_r;

endmodule : pmt_ctrl

// >>> sim/pmt_monitor.sv
/*
 Link checker for the controller and sensor pair.
 Assumes one clock and the same TICK as both ends.
*/
`timescale 1ns/10ps
module pmt_monitor
    import pmt_pkg::*;
#(
    parameter int TICK = TICK_CYC
) (
    input  wire logic        clk_sys,    // clock
    input  wire logic        rst,        // async reset
    input  wire logic        req,        // request
    input  wire logic        wr,         // write
    input  wire logic        rstart,     // repeated start
    input  wire logic [7:0]  cmd,        // command code
    input  wire logic [15:0] wdata,      // write data
    input  wire logic        ack,        // answer
    input  wire logic        int_n,      // interrupt
    input  wire logic        emitter_on, // pulse phase
    input  wire logic        measuring   // active phase
);
    localparam int SAT = 1000000;
    int         por_cnt, gap_cnt, can_cnt, act_cnt, can_min, act_max;
    logic       last_wr, itb_r;
    logic [2:0] it_r, mps_r;
    // ----------
    // helpers
    // ----------
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            por_cnt <= 0;
            gap_cnt <= SAT;
            last_wr <= 1'b0;
        end else begin
            por_cnt <= (por_cnt < SAT) ? por_cnt + 1 : por_cnt;
            gap_cnt <= req ? 1 : ((gap_cnt < SAT) ? gap_cnt + 1 : gap_cnt);
            last_wr <= req ? wr : last_wr;
        end
    end
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            itb_r <= 1'b0;
            it_r  <= 3'h0;
            mps_r <= 3'h0;
        end else if (req && wr && cmd == CMD_CONF2) begin
            itb_r <= wdata[F2_ITB];
            it_r  <= wdata[F2_IT_LSB +: 3];
        end else if (req && wr && cmd == CMD_CONF3) begin
            mps_r <= wdata[F3_MPS_LSB +: 3];
        end
    end
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            can_cnt <= 0;
            act_cnt <= 0;
        end else begin
            can_cnt <= (measuring && !emitter_on) ? can_cnt + 1 : 0;
            act_cnt <= measuring ? act_cnt + 1 : 0;
        end
    end
    always_comb begin
        can_min = (itb_r ? T_CANCEL_50_US : T_CANCEL_25_US) * TICK;
        act_max = 2 * (int'(it_r) + 1) * (itb_r ? T_ITB_50_US : T_ITB_25_US);
        act_max = (can_min + act_max * (int'(mps_r) + 1) * TICK) * SPREAD_NUM / SPREAD_DEN;
    end
    // ----------
    // assertions
    // ----------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    sequence s_rd;
        req && !wr;
    endsequence
    sequence s_flag_rd;
        req && !wr && cmd == CMD_FLAGS;
    endsequence
    chk_ack_pulse: assert property (req |=> ack ##1 !ack)
        else $error("ack not a one-cycle pulse after request");
    chk_ack_cause: assert property (ack |-> $past(req))
        else $error("ack without request");
    chk_read_rstart: assert property (s_rd |-> rstart)
        else $error("read without repeated start");
    // a new event in the clearing cycle keeps the line low
    chk_flag_release: assert property (s_flag_rd ##0 !measuring |=> int_n)
        else $error("interrupt line not released after flag read");
    chk_flag_sticky: assert property (
            !int_n && !(req && !wr && cmd == CMD_FLAGS) |=> !int_n)
        else $error("interrupt line released without flag read");
    chk_por_wait: assert property (req |-> por_cnt >= T_POR_US * TICK - 1)
        else $error("request before power-on interval");
    chk_req_gap: assert property (
            req |-> gap_cnt >= (last_wr ? T_WR_STD_US : T_RD_STD_US) * TICK)
        else $error("requests too close together");
    chk_cancel_len: assert property (
            $rose(emitter_on) |-> can_cnt >= can_min && can_cnt <= can_min + 4)
        else $error("cancel step length wrong");
    chk_emit_inside: assert property (emitter_on |-> measuring)
        else $error("emitter on outside measurement");
    chk_active_max: assert property (measuring |-> act_cnt < act_max)
        else $error("active measurement too long");
endmodule : pmt_monitor

// >>> sim/proximity_measurement_timing_test.sv
/*
 Self-checking bench: controller and sensor joined by the link.
 Assumes TICK of 1 to keep the run short.
*/
`timescale 1ns/10ps
module proximity_measurement_timing_test;
    import pmt_pkg::*;
    localparam int TK = 1;
    logic        clk_sys = 1'b0;
    logic        rst = 1'b1;
    logic        force_md = 1'b0;
    logic [15:0] cfg2 = 16'h0000;
    logic [15:0] cfg3 = 16'h0000;
    logic [15:0] thr_lo = 16'h0000;
    logic [15:0] thr_hi = 16'hFFFF;
    logic [15:0] amb = 16'h0000;
    logic [15:0] refl = 16'h0000;
    logic [15:0] result;
    logic [1:0]  flags;
    logic        res_valid, ready, emitter_on, measuring;
    int          miscompares = 0;
    int          n_compared = 0;
    logic [17:0] notes[$];
    pmt_link_if link_if();
    pmt_sensor #(.TICK(TK)) u_pmt_sensor (.clk_sys(clk_sys), .rst(rst), .link(link_if),
        .ambient_lvl(amb), .reflect_lvl(refl), .emitter_on(emitter_on), .measuring(measuring));
    pmt_ctrl #(.TICK(TK)) u_pmt_ctrl (.clk_sys(clk_sys), .rst(rst), .link(link_if),
        .force_md(force_md), .cfg1(16'h0000), .cfg2(cfg2), .cfg3(cfg3), .thr_lo(thr_lo),
        .thr_hi(thr_hi), .result(result), .res_valid(res_valid), .flags(flags), .ready(ready));
    pmt_monitor #(.TICK(TK)) u_mon (.clk_sys(clk_sys), .rst(rst), .req(link_if.req),
        .wr(link_if.wr), .rstart(link_if.rstart), .cmd(link_if.cmd), .wdata(link_if.wdata),
        .ack(link_if.ack), .int_n(link_if.int_n), .emitter_on(emitter_on), .measuring(measuring));
    always #10 clk_sys = ~clk_sys;

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic tally_and_finish;
        if (miscompares == 0 && n_compared > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : tally_and_finish

    // ----------
    // result watcher
    // ----------
    always @(negedge clk_sys) begin
        if (res_valid === 1'b1) begin
            if (notes.size() == 0) begin
                check("unexpected result", 16'h0001, 16'h0000);
            end else begin
                check("result", result, notes[0][15:0]);
                check("flags", {14'h0000, flags}, {14'h0000, notes[0][17:16]});
                void'(notes.pop_front());
            end
        end
    end

    // one reset-to-results pass with its own settings
    task automatic run(input logic fm, input logic itb, input logic [15:0] lo,
                       input logic [15:0] hi, input logic [15:0] a, input logic [15:0] r,
                       input logic [1:0] ef, input int n);
        int k;
        @(negedge clk_sys);
        rst = 1'b1;
        force_md = fm;
        cfg2 = {8'h00, 1'b0, fm, 3'($urandom), itb, 2'h0};
        cfg3 = {13'h0000, 3'($urandom)};
        thr_lo = lo;
        thr_hi = hi;
        amb = a;
        refl = r;
        repeat (8) @(negedge clk_sys);
        rst = 1'b0;
        repeat (n) notes.push_back({ef, (r > a) ? r - a : 16'h0000});
        for (k = 0; k < 35000 && notes.size() != 0; k++) @(negedge clk_sys);
        check("ready", {15'h0000, ready}, 16'h0001);
        if (notes.size() != 0) begin
            miscompares++;
            tally_and_finish();
        end
    endtask : run

    // ----------
    // main sequence
    // ----------
    initial begin
        logic [15:0] v;
        void'($urandom(68));
        v = 16'($urandom) & 16'h0FFF;
        run(1'b0, 1'b0, 16'h0000, 16'h0800, v, v + 16'h1000, 2'h1, 2);
        v = 16'($urandom) | 16'h8000;
        run(1'b0, 1'b1, 16'h0100, 16'hFFFF, v, v & 16'h7FFF, 2'h2, 1);
        v = 16'($urandom);
        run(1'b1, 1'($urandom), 16'h0000, 16'hFFFF, v, 16'($urandom), 2'h0, 1);
        tally_and_finish();
    end
endmodule : proximity_measurement_timing_test
